// ==== rtl/dos_pkg.sv ====
// Constants, register map and carrier types for the drive output signal select block.
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
package dos_pkg;

  // ---------------------------------------------------------------------------
  // Widths and counts
  // ---------------------------------------------------------------------------
  localparam int N_OUT = 5;
  localparam int N_IN  = 8;
  localparam int N_THR = 4;
  localparam int AW    = 8;
  localparam int DW    = 16;
  localparam int N_IRQ = 7;

  // ---------------------------------------------------------------------------
  // Register offsets (word index on the plain port)
  // ---------------------------------------------------------------------------
  localparam logic [AW-1:0] FN_SEL_BASE = 8'h00;
  localparam logic [AW-1:0] POL_BASE    = 8'h08;
  localparam logic [AW-1:0] IN_SEL_BASE = 8'h10;
  localparam logic [AW-1:0] THR_BASE    = 8'h18;
  localparam logic [AW-1:0] MAXF_ADDR   = 8'h1C;
  localparam logic [AW-1:0] SETP_ADDR   = 8'h1D;
  localparam logic [AW-1:0] STAT_ADDR   = 8'h20;
  localparam logic [AW-1:0] IRQ_ADDR    = 8'h21;
  localparam logic [AW-1:0] MASK_ADDR   = 8'h22;

  // ---------------------------------------------------------------------------
  // Reset values and codes
  // ---------------------------------------------------------------------------
  localparam logic [8*N_OUT-1:0] FN_SEL_RST = {8'h08, 8'h07, 8'h03, 8'h00, 8'h01};
  localparam logic [7:0]  POL_RST    = 8'h00;
  localparam logic [7:0]  POL_BREAK  = 8'h01;
  localparam logic [7:0]  IN_SEL_RST = 8'h00;
  localparam logic [7:0]  IN_BOK     = 8'h2C;
  localparam logic [DW-1:0] THR_RST  = 16'h0000;
  localparam logic [DW-1:0] MAXF_RST = 16'h1770;
  localparam logic [DW-1:0] SETP_RST = 16'h0000;
  localparam logic [N_IRQ-1:0] MASK_RST = 7'h00;

  // Frequencies are in units of 0.01 Hz; 400 Hz is the ceiling.
  localparam logic [DW-1:0] THR_MAX   = 16'h9C40;
  localparam logic [DW:0]   PCT_DIV   = 17'h00064;
  localparam logic [DW:0]   HYST_ON   = 17'h00001;
  localparam logic [DW:0]   HYST_OFF  = 17'h00002;
  localparam int            FN_CODES  = 32;

  // ---------------------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } dos_bus_s;

  typedef struct packed {
    logic run;
    logic overload;
    logic pid_deviation;
    logic fault;
    logic torque_exceeded;
    logic mains_fail_stop;
    logic undervoltage;
    logic torque_limiting;
    logic run_time_exceeded;
    logic power_on_time_exceeded;
    logic motor_thermal;
    logic release_brake;
    logic brake_fault;
    logic zero_speed;
    logic speed_deviation;
    logic positioning_done;
    logic overload2;
  } dos_src_s;

endpackage : dos_pkg

// ==== rtl/dos_top.sv ====
// Output function select, frequency arrival comparators and brake confirmation.
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/100ps
module dos_top
  import dos_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire dos_bus_s         bus,
  output logic [DW-1:0]         rdata,
  input  wire logic [DW-1:0]    output_frequency,
  input  wire logic             accelerating,
  input  wire logic             decelerating,
  input  wire dos_src_s         src,
  input  wire logic [N_IN-1:0]  digital_in,
  output logic [N_OUT-1:0]      dout,
  output logic                  brake_release_confirm,
  output logic                  brake_confirm_assigned,
  output wire logic             irq
);

  // ---------------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------------
  // True when f lies more than band below thr.
  function automatic logic below(input logic [DW-1:0] f,
                                 input logic [DW-1:0] thr,
                                 input logic [DW-1:0] band);
    below = ({1'b0, f} + {1'b0, band}) < {1'b0, thr};
  endfunction : below

  // True when f lies within band of thr on either side.
  function automatic logic in_band(input logic [DW-1:0] f,
                                   input logic [DW-1:0] thr,
                                   input logic [DW-1:0] band);
    in_band = !below(f, thr, band) && !below(thr, f, band);
  endfunction : in_band

  function automatic logic [DW-1:0] clamp_thr(input logic [DW-1:0] d);
    clamp_thr = (d > THR_MAX) ? THR_MAX : d;
  endfunction : clamp_thr

  function automatic logic [DW-1:0] pct(input logic [DW-1:0] m,
                                        input logic [DW:0]   k);
    logic [2*DW+1:0] p;
    p   = ({1'b0, m} * k) / PCT_DIV;
    pct = p[DW-1:0];
  endfunction : pct

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [7:0]       fn_sel [N_OUT];
  logic [7:0]       pol    [N_OUT];
  logic [7:0]       in_sel [N_IN];
  logic [DW-1:0]    thr    [N_THR];
  logic [DW-1:0]    maximum_frequency;
  logic [DW-1:0]    frequency_setpoint;
  logic [N_IRQ-1:0] irq_status;
  logic [N_IRQ-1:0] irq_mask;
  logic             setpoint_reached_out;

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  wire logic           wr_maxf = bus.wr && (bus.addr == MAXF_ADDR);
  wire logic           wr_setp = bus.wr && (bus.addr == SETP_ADDR);
  wire logic           wr_irq  = bus.wr && (bus.addr == IRQ_ADDR);
  wire logic           wr_mask = bus.wr && (bus.addr == MASK_ADDR);
  wire logic [AW-1:0]  off_fn  = bus.addr - FN_SEL_BASE;
  wire logic [AW-1:0]  off_pol = bus.addr - POL_BASE;
  wire logic [AW-1:0]  off_in  = bus.addr - IN_SEL_BASE;
  wire logic [AW-1:0]  off_thr = bus.addr - THR_BASE;
  wire logic           hit_fn  = (bus.addr >= FN_SEL_BASE) && (off_fn < AW'(N_OUT));
  wire logic           hit_pol = (bus.addr >= POL_BASE) && (off_pol < AW'(N_OUT));
  wire logic           hit_in  = (bus.addr >= IN_SEL_BASE) && (off_in < AW'(N_IN));
  wire logic           hit_thr = (bus.addr >= THR_BASE) && (off_thr < AW'(N_THR));

  // ---------------------------------------------------------------------------
  // Configuration storage
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    for (int i = 0; i < N_OUT; i++) begin
      if (!reset_n) begin
        fn_sel[i] <= FN_SEL_RST[8*i +: 8];
        pol[i]    <= POL_RST;
      end else begin
        if (bus.wr && hit_fn && (off_fn == AW'(i))) begin
          fn_sel[i] <= bus.wdata[7:0];
        end
        if (bus.wr && hit_pol && (off_pol == AW'(i))) begin
          pol[i] <= bus.wdata[7:0];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < N_IN; i++) begin
      if (!reset_n) begin
        in_sel[i] <= IN_SEL_RST;
      end else if (bus.wr && hit_in && (off_in == AW'(i))) begin
        in_sel[i] <= bus.wdata[7:0];
      end
    end
  end

  // Values above 400 Hz are clipped on the way in so the exceed and window comparators
  // never see an out-of-range threshold.
  always_ff @(posedge clk) begin
    for (int i = 0; i < N_THR; i++) begin
      if (!reset_n) begin
        thr[i] <= THR_RST;
      end else if (bus.wr && hit_thr && (off_thr == AW'(i))) begin
        thr[i] <= clamp_thr(bus.wdata);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      maximum_frequency  <= MAXF_RST;
      frequency_setpoint <= SETP_RST;
      irq_mask           <= MASK_RST;
    end else begin
      if (wr_maxf) begin
        maximum_frequency <= bus.wdata;
      end
      if (wr_setp) begin
        frequency_setpoint <= bus.wdata;
      end
      if (wr_mask) begin
        irq_mask <= bus.wdata[N_IRQ-1:0];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Brake release confirmation
  // ---------------------------------------------------------------------------
  logic [N_IN-1:0] bok_sel;
  always_comb begin
    for (int i = 0; i < N_IN; i++) begin
      bok_sel[i] = (in_sel[i] == IN_BOK);
    end
  end

  wire logic next_confirm = |(bok_sel & digital_in);
  logic      confirm_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      brake_release_confirm  <= 1'b0;
      brake_confirm_assigned <= 1'b0;
      confirm_q              <= 1'b0;
    end else begin
      brake_release_confirm  <= next_confirm;
      brake_confirm_assigned <= |bok_sel;
      confirm_q              <= brake_release_confirm;
    end
  end

  // ---------------------------------------------------------------------------
  // Frequency arrival comparators
  // ---------------------------------------------------------------------------
  // Bands are recomputed every cycle from the end frequency; the divider is
  // combinational because the clock is slow and the saving in state is worth it.
  wire logic [DW-1:0] band_on  = pct(maximum_frequency, HYST_ON);
  wire logic [DW-1:0] band_off = pct(maximum_frequency, HYST_OFF);
  wire logic [DW-1:0] fo       = output_frequency;

  wire logic sp_set = in_band(fo, frequency_setpoint, band_on);
  wire logic sp_clr = !in_band(fo, frequency_setpoint, band_off);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      setpoint_reached_out <= 1'b0;
    end else if (sp_set) begin
      setpoint_reached_out <= 1'b1;
    end else if (sp_clr) begin
      setpoint_reached_out <= 1'b0;
    end
  end

  logic [1:0] exc_v;
  logic [1:0] win_v;

  for (genvar g = 0; g < 2; g++) begin : g_pair
    wire logic [DW-1:0] ta = thr[2*g];
    wire logic [DW-1:0] td = thr[2*g+1];
    logic exc;
    logic win;
    logic pt_dec;

    wire logic exc_set = accelerating && !below(fo, ta, band_on);
    wire logic exc_clr = (decelerating && below(fo, td, band_off)) ||
                         (accelerating && below(fo, ta, band_off));
    wire logic near_a  = accelerating && in_band(fo, ta, band_on);
    wire logic near_d  = decelerating && in_band(fo, td, band_on);
    wire logic win_clr = !in_band(fo, pt_dec ? td : ta, band_off);

    always_ff @(posedge clk) begin
      if (!reset_n) begin
        exc <= 1'b0;
      end else if (exc_set) begin
        exc <= 1'b1;
      end else if (exc_clr) begin
        exc <= 1'b0;
      end
    end

    always_ff @(posedge clk) begin
      if (!reset_n) begin
        win    <= 1'b0;
        pt_dec <= 1'b0;
      end else if (near_a || near_d) begin
        win    <= 1'b1;
        pt_dec <= near_d;
      end else if (win_clr) begin
        win    <= 1'b0;
      end
    end

    assign exc_v[g] = exc;
    assign win_v[g] = win;
  end

  wire logic threshold_exceeded_out  = exc_v[0];
  wire logic window_reached_out      = win_v[0];
  wire logic threshold_exceeded2_out = exc_v[1];
  wire logic window_reached2_out     = win_v[1];

  // ---------------------------------------------------------------------------
  // Function table and output select
  // ---------------------------------------------------------------------------
  // Unlisted codes stay zero, so a reserved selection reads as inactive.
  logic [FN_CODES-1:0] fn_vec;
  always_comb begin
    fn_vec     = '0;
    fn_vec[0]  = src.run;
    fn_vec[1]  = setpoint_reached_out;
    fn_vec[2]  = threshold_exceeded_out;
    fn_vec[3]  = src.overload;
    fn_vec[4]  = src.pid_deviation;
    fn_vec[5]  = src.fault;
    fn_vec[6]  = window_reached_out;
    fn_vec[7]  = src.torque_exceeded;
    fn_vec[8]  = src.mains_fail_stop;
    fn_vec[9]  = src.undervoltage;
    fn_vec[10] = src.torque_limiting;
    fn_vec[11] = src.run_time_exceeded;
    fn_vec[12] = src.power_on_time_exceeded;
    fn_vec[13] = src.motor_thermal;
    fn_vec[19] = src.release_brake;
    fn_vec[20] = src.brake_fault;
    fn_vec[21] = src.zero_speed;
    fn_vec[22] = src.speed_deviation;
    fn_vec[23] = src.positioning_done;
    fn_vec[24] = threshold_exceeded2_out;
    fn_vec[25] = window_reached2_out;
    fn_vec[26] = src.overload2;
  end

  logic [N_OUT-1:0] next_dout;
  always_comb begin
    for (int i = 0; i < N_OUT; i++) begin
      next_dout[i] = ((fn_sel[i] < 8'(FN_CODES)) ? fn_vec[fn_sel[i][4:0]] : 1'b0)
                     ^ (pol[i] == POL_BREAK);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dout <= '0;
    end else begin
      dout <= next_dout;
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------------------
  logic [N_OUT-1:0] dout_q;
  wire logic [N_IRQ-1:0] irq_event = {confirm_q & ~brake_release_confirm,
                                      brake_release_confirm & ~confirm_q,
                                      dout ^ dout_q};
  wire logic [N_IRQ-1:0] irq_clr = wr_irq ? bus.wdata[N_IRQ-1:0] : '0;

  // A new event in the clearing cycle survives the write-one-to-clear.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dout_q     <= '0;
      irq_status <= '0;
    end else begin
      dout_q     <= dout;
      irq_status <= (irq_status & ~irq_clr) | irq_event;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  logic [DW-1:0] next_rdata;
  always_comb begin
    next_rdata = '0;
    if (bus.rd) begin
      if (hit_fn) begin
        next_rdata = {8'h00, fn_sel[off_fn[2:0]]};
      end else if (hit_pol) begin
        next_rdata = {8'h00, pol[off_pol[2:0]]};
      end else if (hit_in) begin
        next_rdata = {8'h00, in_sel[off_in[2:0]]};
      end else if (hit_thr) begin
        next_rdata = thr[off_thr[1:0]];
      end else if (bus.addr == MAXF_ADDR) begin
        next_rdata = maximum_frequency;
      end else if (bus.addr == SETP_ADDR) begin
        next_rdata = frequency_setpoint;
      end else if (bus.addr == STAT_ADDR) begin
        next_rdata = {2'b00, brake_confirm_assigned, brake_release_confirm,
                      window_reached2_out, threshold_exceeded2_out,
                      window_reached_out, threshold_exceeded_out,
                      setpoint_reached_out, 2'b00, dout};
      end else if (bus.addr == IRQ_ADDR) begin
        next_rdata = {9'h000, irq_status};
      end else if (bus.addr == MASK_ADDR) begin
        next_rdata = {9'h000, irq_mask};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end

endmodule : dos_top

// ==== tb/dos_brake_model.sv ====
// Behavioural external brake that reports back when its lining is lifted.
`timescale 1ns/100ps
module dos_brake_model #(
  parameter int DLY = 4
) (
  input  wire logic clk,
  input  wire logic release_cmd,
  output logic      released
);
  // ----
  // Brake unit
  // ----
  // The lining takes time to move, so the feedback lags the command both ways.
  int cnt = 0;
  initial released = 1'b0;
  always @(posedge clk) begin
    cnt <= (release_cmd != released) ? cnt + 1 : 0;
    if (cnt == DLY) begin
      released <= release_cmd;
      cnt      <= 0;
    end
  end
endmodule : dos_brake_model

// ==== tb/dos_top_assertions.sv ====
// Concurrent checks on the ports of the output select block.
`timescale 1ns/100ps
module dos_top_assertions
  import dos_pkg::*;
(
  input wire logic             clk,
  input wire logic             reset_n,
  input wire dos_bus_s         bus,
  input wire logic [DW-1:0]    rdata,
  input wire logic [DW-1:0]    output_frequency,
  input wire logic             accelerating,
  input wire logic             decelerating,
  input wire dos_src_s         src,
  input wire logic [N_IN-1:0]  digital_in,
  input wire logic [N_OUT-1:0] dout,
  input wire logic             brake_release_confirm,
  input wire logic             brake_confirm_assigned,
  input wire logic             irq
);
  // ----
  // Shadow of the selectors, so each output can be tied to its source.
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [7:0]       sel_h [N_OUT];
  logic [N_OUT-1:0] inv_h;
  always_ff @(posedge clk) begin
    for (int i = 0; i < N_OUT; i++) begin
      if (!reset_n) begin
        sel_h[i] <= FN_SEL_RST[8*i +: 8];
        inv_h[i] <= 1'b0;
      end else if (bus.wr && bus.addr == FN_SEL_BASE + 8'(i)) begin
        sel_h[i] <= bus.wdata[7:0];
      end else if (bus.wr && bus.addr == POL_BASE + 8'(i)) begin
        inv_h[i] <= (bus.wdata[7:0] == POL_BREAK);
      end
    end
  end
  for (genvar g = 0; g < N_OUT; g++) begin : g_out
    a_run_select:
      assert property ($past(sel_h[g]) == 8'h00 |-> dout[g] == ($past(src.run) ^ $past(inv_h[g])))
      else $error("run code does not follow its source");
    a_thermal_select:
      assert property ($past(sel_h[g]) == 8'h0D |->
        dout[g] == ($past(src.motor_thermal) ^ $past(inv_h[g])))
      else $error("thermal code does not follow its source");
    a_brake_select:
      assert property ($past(sel_h[g]) == 8'h13 |->
        dout[g] == ($past(src.release_brake) ^ $past(inv_h[g])))
      else $error("brake code does not follow its source");
    a_ovl2_select:
      assert property ($past(sel_h[g]) == 8'h1A |->
        dout[g] == ($past(src.overload2) ^ $past(inv_h[g])))
      else $error("second overload code does not follow its source");
    a_reserved_quiet:
      assert property ($past(sel_h[g]) inside {[8'h0E:8'h12], [8'h1B:8'hFF]} |->
        dout[g] == $past(inv_h[g]))
      else $error("reserved code drives an output");
  end
  a_confirm_owner:
    assert property (brake_release_confirm |-> brake_confirm_assigned)
    else $error("confirm without an assigned input");
  a_confirm_drop:
    assert property (!$past(|digital_in) |-> !brake_release_confirm)
    else $error("confirm high with all inputs low");
  a_rdata_idle:
    assert property (!$past(bus.rd) |-> rdata == '0)
    else $error("read data outside its cycle");
  a_dout_reset:
    assert property ($rose(reset_n) |-> dout == '0)
    else $error("outputs not open after reset");
endmodule : dos_top_assertions
bind dos_top dos_top_assertions i_dos_top_assertions (
  .clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
  .output_frequency(output_frequency), .accelerating(accelerating),
  .decelerating(decelerating), .src(src), .digital_in(digital_in), .dout(dout),
  .brake_release_confirm(brake_release_confirm),
  .brake_confirm_assigned(brake_confirm_assigned), .irq(irq));

// ==== tb/dos_top_tb.sv ====
// Self-checking bench for the output select block.
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module dos_top_tb
  import dos_pkg::*;
;
  // ----
  // Stimulus and design
  // ----
  localparam int F1 = int'(MAXF_RST) / 100;
  localparam logic [7:0] CODE [17] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08, 8'h09,
    8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h1A};
  localparam logic [7:0] RSV [7] = '{8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h1B, 8'hFF};
  logic             clk = 1'b0;
  logic             reset_n = 1'b0;
  dos_bus_s         bus = '0;
  logic [DW-1:0]    fo = '0;
  logic             acc = 1'b0;
  logic             dec = 1'b0;
  dos_src_s         src = '0;
  logic [N_IN-1:1]  din_hi = '0;
  logic [DW-1:0]    rdata;
  logic [N_OUT-1:0] dout;
  logic             conf;
  logic             assigned;
  logic             irq;
  logic             brake_fb;
  int               fails = 0;
  int               check_count = 0;
  int               cycles = 0;
  dos_top i_dos_top (.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
    .output_frequency(fo), .accelerating(acc), .decelerating(dec), .src(src),
    .digital_in({din_hi, brake_fb}), .dout(dout), .brake_release_confirm(conf),
    .brake_confirm_assigned(assigned), .irq(irq));
  dos_brake_model i_dos_brake_model (.clk(clk), .release_cmd(dout[4]), .released(brake_fb));
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      test_done();
    end
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input string n);
    @(posedge clk);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    `CHK(n, e, rdata)
  endtask : rd
  task automatic pause;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : pause
  task automatic drive(input int f, input logic a, input logic d);
    @(posedge clk);
    fo  <= f[DW-1:0];
    acc <= a;
    dec <= d;
    pause();
  endtask : drive
  task automatic pair_test(input logic [7:0] ta, input logic [7:0] ce, input logic [7:0] cw);
    wr(ta, 16'd4000);
    wr(ta + 8'h01, 16'd3000);
    wr(FN_SEL_BASE + 8'h02, {8'h00, ce});
    wr(FN_SEL_BASE + 8'h03, {8'h00, cw});
    drive(0, 1'b1, 1'b0);
    drive(4000 - F1 - 10, 1'b1, 1'b0);
    `CHK("exceed early", 1'b0, dout[2])
    `CHK("window early", 1'b0, dout[3])
    drive(4000 - F1, 1'b1, 1'b0);
    `CHK("exceed set", 1'b1, dout[2])
    `CHK("window set", 1'b1, dout[3])
    drive(4000 + 2 * F1 + 10, 1'b1, 1'b0);
    `CHK("exceed above", 1'b1, dout[2])
    `CHK("window left", 1'b0, dout[3])
    drive(3000 + F1 - 10, 1'b0, 1'b1);
    `CHK("exceed held", 1'b1, dout[2])
    `CHK("window decel", 1'b1, dout[3])
    drive(3000 - 2 * F1 - 10, 1'b0, 1'b1);
    `CHK("exceed off", 1'b0, dout[2])
    `CHK("window off", 1'b0, dout[3])
  endtask : pair_test
  // ----
  // Test sequence
  // ----
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < N_OUT; i++) begin
      rd(FN_SEL_BASE + 8'(i), {8'h00, FN_SEL_RST[8*i +: 8]}, "select reset");
      rd(POL_BASE + 8'(i), 16'h0000, "polarity reset");
    end
    rd(MAXF_ADDR, MAXF_RST, "maximum frequency");
    rd(8'h30, 16'h0000, "unmapped");
    wr(FN_SEL_BASE, 16'hAB01);
    rd(FN_SEL_BASE, 16'h0001, "select upper bits");
    wr(THR_BASE, 16'hFFFF);
    rd(THR_BASE, THR_MAX, "threshold ceiling");
    $display("test registers done");
    for (int k = 0; k < 17; k++) begin
      wr(FN_SEL_BASE + 8'h01, {8'h00, CODE[k]});
      src <= dos_src_s'(17'h10000 >> k);
      pause();
      `CHK("source on", 1'b1, dout[1])
      @(posedge clk);
      src <= dos_src_s'(~(17'h10000 >> k));
      pause();
      `CHK("source off", 1'b0, dout[1])
    end
    @(posedge clk);
    src <= '1;
    for (int k = 0; k < 7; k++) begin
      wr(FN_SEL_BASE + 8'h01, {8'h00, RSV[k]});
      pause();
      `CHK("reserved code", 1'b0, dout[1])
    end
    wr(POL_BASE + 8'h01, 16'h0001);
    pause();
    `CHK("break contact", 1'b1, dout[1])
    @(posedge clk);
    src <= '0;
    $display("test selection done");
    wr(SETP_ADDR, 16'd3000);
    drive(2000, 1'b0, 1'b0);
    `CHK("setpoint far", 1'b0, dout[0])
    drive(3000 - F1 + 5, 1'b1, 1'b0);
    `CHK("setpoint met", 1'b1, dout[0])
    drive(3000 - 2 * F1 + 10, 1'b0, 1'b1);
    `CHK("setpoint held", 1'b1, dout[0])
    drive(3000 - 2 * F1 - 10, 1'b0, 1'b1);
    `CHK("setpoint left", 1'b0, dout[0])
    pair_test(THR_BASE, 8'h02, 8'h06);
    pair_test(THR_BASE + 8'h02, 8'h18, 8'h19);
    $display("test arrival done");
    wr(MASK_ADDR, 16'h0020);
    wr(IRQ_ADDR, 16'h007F);
    wr(IN_SEL_BASE, {8'h00, IN_BOK});
    wr(FN_SEL_BASE + 8'h04, 16'h0013);
    src.release_brake <= 1'b1;
    for (int w = 0; w < 50 && conf !== 1'b1; w++) @(negedge clk);
    // The status bit lands one edge after the confirm flop rises.
    @(negedge clk);
    `CHK("confirm on", 1'b1, conf)
    `CHK("confirm input", 1'b1, assigned)
    `CHK("irq raised", 1'b1, irq)
    wr(MASK_ADDR, 16'h0000);
    @(negedge clk);
    `CHK("irq masked", 1'b0, irq)
    wr(MASK_ADDR, 16'h0020);
    @(negedge clk);
    `CHK("irq unmasked", 1'b1, irq)
    wr(IRQ_ADDR, 16'h0020);
    @(negedge clk);
    `CHK("irq cleared", 1'b0, irq)
    @(posedge clk);
    src.release_brake <= 1'b0;
    for (int w = 0; w < 50 && conf !== 1'b0; w++) @(negedge clk);
    `CHK("confirm off", 1'b0, conf)
    @(posedge clk);
    din_hi <= 7'h7F;
    pause();
    `CHK("unassigned inputs", 1'b0, conf)
    $display("test brake done");
    test_done();
  end
endmodule : dos_top_tb
